// File: logic/pic_pkg.sv
// Package with register map, field layout, reset values and divider table of the periodic interrupt counter.
package pic_pkg;

    localparam int unsigned PIC_ADDR_W = 12;
    localparam int unsigned PIC_DATA_W = 32;
    localparam int unsigned PIC_PRESC_W = 18;

    localparam logic [PIC_ADDR_W-1:0] PIC_OFS_STATUS_CONTROL = 12'h000;
    localparam logic [PIC_ADDR_W-1:0] PIC_OFS_COUNT_VALUE = 12'h004;
    localparam logic [PIC_ADDR_W-1:0] PIC_OFS_WRAP_LIMIT = 12'h008;

    localparam int unsigned PIC_BIT_MATCH_FLAG = 7;
    localparam int unsigned PIC_BIT_SRC_HI = 6;
    localparam int unsigned PIC_BIT_SRC_LO = 5;
    localparam int unsigned PIC_BIT_IRQ_EN = 4;
    localparam int unsigned PIC_BIT_DIV_HI = 3;
    localparam int unsigned PIC_BIT_DIV_LO = 0;

    localparam logic [1:0] PIC_SRC_LOW_POWER = 2'h0;
    localparam logic [1:0] PIC_SRC_EXTERNAL = 2'h1;

    localparam logic [7:0] PIC_RST_BYTE = 8'h00;
    localparam logic [1:0] PIC_RST_SRC = 2'h0;
    localparam logic [3:0] PIC_RST_DIV = 4'h0;
    localparam logic [3:0] PIC_DIV_OFF = 4'h0;
    localparam logic [PIC_PRESC_W-1:0] PIC_RST_PRESC = 18'h00000;
    localparam logic [PIC_DATA_W-1:0] PIC_RST_WORD = 32'h00000000;

    localparam logic [1:0] PIC_RESP_OKAY = 2'h0;
    localparam logic [1:0] PIC_RESP_SLVERR = 2'h2;

    // Divide ratio for a divider select code; low-ratio bank (1 to 1024) when the source bit 0 is clear.
    function automatic logic [PIC_PRESC_W-1:0] pic_divisor(input logic src_bit0, input logic [3:0] code);
        logic [PIC_PRESC_W-1:0] d;
        d = 18'h00001;
        if (!src_bit0) begin
            unique case (code)
                4'h0: d = 18'h00001;
                4'h1: d = 18'h00008;
                4'h2: d = 18'h00020;
                4'h3: d = 18'h00040;
                4'h4: d = 18'h00080;
                4'h5: d = 18'h00100;
                4'h6: d = 18'h00200;
                4'h7: d = 18'h00400;
                4'h8: d = 18'h00001;
                4'h9: d = 18'h00002;
                4'ha: d = 18'h00004;
                4'hb: d = 18'h0000a;
                4'hc: d = 18'h00010;
                4'hd: d = 18'h00064;
                4'he: d = 18'h001f4;
                4'hf: d = 18'h003e8;
            endcase
        end else begin
            unique case (code)
                4'h0: d = 18'h00001;
                4'h1: d = 18'h00400;
                4'h2: d = 18'h00800;
                4'h3: d = 18'h01000;
                4'h4: d = 18'h02000;
                4'h5: d = 18'h04000;
                4'h6: d = 18'h08000;
                4'h7: d = 18'h10000;
                4'h8: d = 18'h003e8;
                4'h9: d = 18'h007d0;
                4'ha: d = 18'h01388;
                4'hb: d = 18'h02710;
                4'hc: d = 18'h04e20;
                4'hd: d = 18'h0c350;
                4'he: d = 18'h186a0;
                4'hf: d = 18'h30d40;
            endcase
        end
        return d;
    endfunction

endpackage

// File: logic/pic_top.sv
// Periodic interrupt counter with AXI4-Lite register access and selectable prescaled source.
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
module pic_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [pic_pkg::PIC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [pic_pkg::PIC_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pic_pkg::PIC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [pic_pkg::PIC_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic low_power_1khz_osc,
    input wire logic external_ref_clock,
    input wire logic internal_ref_clock,
    input wire logic debug_halt,
    output logic periodic_irq
);
    import pic_pkg::*;

    typedef struct packed {
        logic awready;
        logic wready;
        logic arready;
        logic aw_held;
        logic [PIC_ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [PIC_DATA_W-1:0] rdata;
        logic match_flag;
        logic [1:0] source_select;
        logic periodic_irq_enable;
        logic [3:0] divider_select;
        logic [7:0] wrap_limit;
        logic [7:0] count_value;
        logic [PIC_PRESC_W-1:0] presc;
        logic [2:0] sync_a;
        logic [2:0] sync_b;
        logic [2:0] sync_c;
        logic irq;
    } pic_state_t;

    pic_state_t s;
    pic_state_t next_s;

    logic [2:0] src_pins;
    assign src_pins = {internal_ref_clock, external_ref_clock, low_power_1khz_osc};

    always_comb begin
        logic do_write;
        logic do_read;
        logic restart;
        logic src_edge;
        logic tick;
        logic [2:0] edges;
        logic [PIC_PRESC_W-1:0] div;
        logic [7:0] wb;
        do_write = 1'b0;
        do_read = 1'b0;
        restart = 1'b0;
        src_edge = 1'b0;
        tick = 1'b0;
        edges = 3'h0;
        div = 18'h00001;
        wb = 8'h00;
        next_s = s;

        // Each source pin passes two flip-flops; the third stage only serves edge detection.
        next_s.sync_a = src_pins;
        next_s.sync_b = s.sync_a;
        next_s.sync_c = s.sync_b;
        edges = s.sync_b & ~s.sync_c;

        // Source pick: 00 low power, 01 external, 1x internal.
        if (s.source_select == PIC_SRC_LOW_POWER) begin
            src_edge = edges[0];
        end else if (s.source_select == PIC_SRC_EXTERNAL) begin
            src_edge = edges[1];
        end else begin
            src_edge = edges[2];
        end

        div = pic_divisor(s.source_select[0], s.divider_select);

        // Write address and data are taken independently and held until both are present.
        if (s_axi_awvalid && s.awready) begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            next_s.w_held = 1'b1;
            next_s.w_data = s_axi_wdata[7:0];
            next_s.w_lane0 = s_axi_wstrb[0];
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        if (next_s.aw_held && next_s.w_held && !next_s.bvalid) begin
            do_write = 1'b1;
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = PIC_RESP_OKAY;
        end

        wb = next_s.w_data;

        // Counting: halted in debug and while the divider is off.
        if (!debug_halt && s.divider_select != PIC_DIV_OFF && src_edge) begin
            if (s.presc >= div - 18'h00001) begin
                next_s.presc = PIC_RST_PRESC;
                tick = 1'b1;
            end else begin
                next_s.presc = s.presc + 18'h00001;
            end
        end
        if (tick) begin
            if (s.count_value == s.wrap_limit) begin
                next_s.count_value = PIC_RST_BYTE;
                next_s.match_flag = 1'b1;
            end else begin
                next_s.count_value = s.count_value + 8'h01;
            end
        end

        if (do_write) begin
            unique case (next_s.aw_addr)
                PIC_OFS_STATUS_CONTROL: begin
                    if (next_s.w_lane0) begin
                        // A match in this same cycle wins over the clear.
                        if (wb[PIC_BIT_MATCH_FLAG] && !(tick && s.count_value == s.wrap_limit)) begin
                            next_s.match_flag = 1'b0;
                        end
                        if (wb[PIC_BIT_SRC_HI:PIC_BIT_SRC_LO] != s.source_select) begin
                            restart = 1'b1;
                        end
                        if (wb[PIC_BIT_DIV_HI:PIC_BIT_DIV_LO] != s.divider_select) begin
                            restart = 1'b1;
                        end
                        next_s.source_select = wb[PIC_BIT_SRC_HI:PIC_BIT_SRC_LO];
                        next_s.periodic_irq_enable = wb[PIC_BIT_IRQ_EN];
                        next_s.divider_select = wb[PIC_BIT_DIV_HI:PIC_BIT_DIV_LO];
                    end
                end
                PIC_OFS_COUNT_VALUE: begin
                    // Count register ignores writes.
                    next_s.bresp = PIC_RESP_OKAY;
                end
                PIC_OFS_WRAP_LIMIT: begin
                    if (next_s.w_lane0) begin
                        next_s.wrap_limit = wb;
                        restart = 1'b1;
                    end
                end
                default: begin
                    next_s.bresp = PIC_RESP_SLVERR;
                end
            endcase
        end

        if (restart) begin
            next_s.presc = PIC_RST_PRESC;
            next_s.count_value = PIC_RST_BYTE;
        end

        // Read channel: one read at a time, data captured at acceptance.
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s.arready) begin
            do_read = 1'b1;
        end
        if (do_read) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = PIC_RESP_OKAY;
            next_s.rdata = PIC_RST_WORD;
            unique case (s_axi_araddr)
                PIC_OFS_STATUS_CONTROL: begin
                    next_s.rdata[PIC_BIT_MATCH_FLAG] = s.match_flag;
                    next_s.rdata[PIC_BIT_SRC_HI:PIC_BIT_SRC_LO] = s.source_select;
                    next_s.rdata[PIC_BIT_IRQ_EN] = s.periodic_irq_enable;
                    next_s.rdata[PIC_BIT_DIV_HI:PIC_BIT_DIV_LO] = s.divider_select;
                end
                PIC_OFS_COUNT_VALUE: begin
                    next_s.rdata[7:0] = s.count_value;
                end
                PIC_OFS_WRAP_LIMIT: begin
                    next_s.rdata[7:0] = s.wrap_limit;
                end
                default: begin
                    next_s.rresp = PIC_RESP_SLVERR;
                end
            endcase
        end

        next_s.irq = next_s.match_flag && next_s.periodic_irq_enable;

        next_s.awready = !next_s.aw_held && !next_s.bvalid;
        next_s.wready = !next_s.w_held && !next_s.bvalid;
        next_s.arready = !next_s.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rdata = s.rdata;
    assign periodic_irq = s.irq;

endmodule

// File: sim/pic_checker.sv
// Checker of bus handshakes and reset state of the periodic interrupt counter.
module pic_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [pic_pkg::PIC_DATA_W-1:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic periodic_irq
);
    import pic_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (s_wr_take |=> s_axi_bvalid)
        else $error("write got no response");
    a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read got no response");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data above bit 7 not zero");
    a_reset_clear: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !periodic_irq)
        else $error("outputs not cleared by reset");
endmodule

bind pic_top pic_checker pic_checker_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .periodic_irq);

// File: sim/tb.sv
// Self-checking bench of the periodic interrupt counter.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pic_pkg::*;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, debug_halt = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, periodic_irq;
    logic [2:0] osc = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb = 0;
    logic [3:0] strb = 4'h1;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    int n_errors = 0, compares = 0, pres = 0, cnt = 0, flg = 0, wrap = 0, src = 0, en = 0, dv = 0;
    int t0 [16] = '{0, 8, 32, 64, 128, 256, 512, 1024, 1, 2, 4, 10, 16, 100, 500, 1000};
    int t1 [16] = '{0, 1024, 2048, 4096, 8192, 16384, 32768, 65536, 1000, 2000, 5000, 10000, 20000, 50000,
        100000, 200000};
    `define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
        $display("[FAIL] t=%0t got %h exp %h", $time, (g), (e)); end end
    pic_top pic_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .low_power_1khz_osc(osc[0]), .external_ref_clock(osc[1]),
        .internal_ref_clock(osc[2]), .debug_halt, .periodic_irq);
    initial forever #10 aclk = ~aclk;
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= strb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        rs = s_axi_bresp;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rv = s_axi_rdata;
        rs = s_axi_rresp;
    endtask
    // A negative limit leaves the wrap limit register unwritten.
    task automatic cfg(input int s, input int e, input int d, input int w, input int clr);
        if (s != src || d != dv) begin
            pres = 0;
            cnt = 0;
        end
        src = s;
        en = e;
        dv = d;
        if (clr) flg = 0;
        wr(PIC_OFS_STATUS_CONTROL, 32'({clr[0], s[1:0], e[0], d[3:0]}));
        `CHK(rs, PIC_RESP_OKAY)
        if (w >= 0) begin
            wr(PIC_OFS_WRAP_LIMIT, 32'(w));
            wrap = w;
            pres = 0;
            cnt = 0;
        end
    endtask
    // Unselected sources pulse on odd steps so a wrong selection shows in the count.
    task automatic pulse(input int n, input int h);
        logic [2:0] sel;
        sel = 3'(1 << (src > 1 ? 2 : src));
        for (int i = 0; i < n; i++) begin
            debug_halt <= (i < h);
            osc <= sel | (i[0] ? ~sel : 3'h0);
            repeat (3) @(posedge aclk);
            osc <= 3'h0;
            repeat (3) @(posedge aclk);
            if (dv != 0 && i >= h) begin
                pres++;
                if (pres == (src[0] ? t1[dv] : t0[dv])) begin
                    pres = 0;
                    flg = flg | (cnt == wrap);
                    cnt = (cnt == wrap) ? 0 : cnt + 1;
                end
            end
        end
        debug_halt <= 1'b0;
    endtask
    task automatic chk();
        rd(PIC_OFS_COUNT_VALUE);
        `CHK(rv, 32'(cnt))
        `CHK(rs, PIC_RESP_OKAY)
        rd(PIC_OFS_STATUS_CONTROL);
        `CHK(rv, 32'({flg[0], src[1:0], en[0], dv[3:0]}))
        `CHK(periodic_irq, flg[0] & en[0])
        rd(PIC_OFS_WRAP_LIMIT);
        `CHK(rv, 32'(wrap))
        $display("test done count %0d flag %0d", cnt, flg);
    endtask
    task automatic final_report();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge aclk);
        n_errors++;
        final_report();
    end
    initial begin
        void'($urandom(25635));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        chk();
        wr(PIC_OFS_COUNT_VALUE, 32'h0000005a);
        `CHK(rs, PIC_RESP_OKAY)
        wr(12'h00c, 32'h000000ff);
        `CHK(rs, PIC_RESP_SLVERR)
        rd(12'h00c);
        `CHK(rv, 32'h00000000)
        `CHK(rs, PIC_RESP_SLVERR)
        cfg(0, 1, 0, 3, 0);
        pulse(4, 0);
        chk();
        cfg(0, 1, 8, 3, 0);
        pulse(10, 0);
        wr(PIC_OFS_COUNT_VALUE, 32'h000000a5);
        `CHK(rs, PIC_RESP_OKAY)
        chk();
        cfg(0, 1, 8, -1, 0);
        pulse(3, 0);
        // A write with lane 0 off must leave the wrap limit and the count alone.
        strb = 4'h0;
        wr(PIC_OFS_WRAP_LIMIT, 32'h000000ee);
        strb = 4'h1;
        `CHK(rs, PIC_RESP_OKAY)
        chk();
        cfg(0, 1, 8, -1, 1);
        chk();
        cfg(0, 1, 9, -1, 0);
        chk();
        cfg(1, 1, 8, 0, 1);
        pulse(1001, 0);
        chk();
        cfg(3, 0, 8, 1, 1);
        pulse(2001, 0);
        chk();
        cfg(2, 1, 11, 0, 1);
        pulse(25, 4);
        chk();
        repeat (4) begin
            cfg(2 * $urandom_range(1, 0), $urandom_range(1, 0), $urandom_range(12, 8), $urandom_range(7, 0), 1);
            pulse($urandom_range(40, 0), $urandom_range(3, 0));
            chk();
        end
        cfg(0, 1, 8, 0, 1);
        pulse(2, 0);
        chk();
        // Reset in mid-run with the flag and the request raised.
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        pres = 0;
        cnt = 0;
        flg = 0;
        wrap = 0;
        src = 0;
        en = 0;
        dv = 0;
        chk();
        final_report();
    end
endmodule
